// *** src/term_pkg.sv ***
//------------------------------------------------------------
// Purpose: shared constants and types of the termination control
// Assumes: APB with 32-bit data, registers on aligned words
// Notes:   all latencies in clock cycles of CLK
//------------------------------------------------------------
package term_pkg;

   // -----------------------------------------------------------
   // register map
   // -----------------------------------------------------------
   localparam logic [11:0] CFG_OFF = 12'h000;
   localparam logic [11:0] STAT_OFF = 12'h004;
   localparam int CFG_W = 13;

   // -----------------------------------------------------------
   // latency constants
   // -----------------------------------------------------------
   localparam logic [4:0] LAT_OFFSET = 5'h02;    // term latency = cwl + al - 2
   localparam logic [4:0] LAT_MIN = 5'h03;       // cwl >= 5 and al >= 0
   localparam logic [5:0] CHOP_EXTRA = 6'h04;    // burst chop four return
   localparam logic [5:0] EIGHT_EXTRA = 6'h06;   // burst length eight return

   // configuration word, laid out exactly as the CFG register bits
   typedef struct packed {
      logic [3:0] al;        // additive latency
      logic [3:0] cwl;       // cas write latency
      logic [1:0] rtt_wr;    // write termination select
      logic [2:0] rtt_nom;   // nominal termination select
   } cfg_s;

   localparam cfg_s CFG_RST = '{al: 4'h0, cwl: 4'h5, rtt_wr: 2'h0, rtt_nom: 3'h0};

   // whole state of the top module except the delay line
   typedef struct packed {
      logic s1;              // pin synchroniser, first stage
      logic s2;              // pin synchroniser, second stage
      cfg_s cfg;
      logic [5:0] wcnt;      // cycles since the newest write
      logic wact;            // write-strength window running
      logic chop;            // newest write was a chop four
      logic term_en;
      logic wsel;
      logic [2:0] code;
      logic [31:0] rdata;
   } st_s;

   localparam st_s ST_RST = '{s1: 1'b0, s2: 1'b0, cfg: CFG_RST, wcnt: 6'h00, wact: 1'b0,
                              chop: 1'b0, term_en: 1'b0, wsel: 1'b0, code: 3'h0,
                              rdata: 32'h0000_0000};

endpackage

// *** src/term_delay.sv ***
//------------------------------------------------------------
// Purpose: variable-tap delay line for the internal term request
// Assumes: tap is stable except after software reconfiguration
// Notes:   dout is a plain tap of the shift register
//------------------------------------------------------------
`timescale 1ns/10ps
module term_delay #(
   parameter int DEPTH = 32,
   parameter int TAP_W = $clog2(DEPTH)
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic DIN,
   input wire logic [TAP_W-1:0] TAP,
   output logic DOUT
);

   logic [DEPTH-1:0] sh_ff;
   logic [DEPTH-1:0] nxt_sh;

   // shift one place each cycle, newest sample at bit 0
   always_comb begin
      nxt_sh = {sh_ff[DEPTH-2:0], DIN};
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sh_ff <= '0;
      end else begin
         sh_ff <= nxt_sh;
      end
   end

   assign DOUT = sh_ff[TAP];

endmodule

// *** src/term_ctrl.sv ***
//------------------------------------------------------------
// Purpose: on-die termination control, synchronous and dynamic mode
// Assumes: pin sampled through two flops, write decode on CLK
// Notes:   APB slave answers without wait states
//------------------------------------------------------------
// Overview of operation
// RULE1: controller drops the pin early enough that termination is off before read preamble
// RULE2: controller re-enables termination only after the read postamble ends
// RULE3: termination returns once the output drivers stop driving after a read
// RULE4: dynamic mode is on when either write-termination bit is one
// RULE5: nominal strength comes from the three nominal-select bits
// RULE6: write strength comes from the two write-select bits
// RULE7: without writes nominal strength applies, switched by pin and latencies
// RULE8: any write switches to write strength write latency minus two later
// RULE9: chop-four write returns to nominal four plus turn-off latency later
// RULE10: length-eight write returns to nominal six plus turn-off latency later
// RULE11: on/off comes only from pin and latencies, writes pick strength
// RULE12: controller clears both write-select bits when running with dll off
// RULE13: controller keeps the pin high at least four cycles
// RULE14: pin with write stays high four or six cycles after the write
// RULE15: on and off follow the sampled pin by write latency minus two
// RULE16: pin is ignored unless some termination select bit is nonzero
// RULE17: latencies equal cas write latency plus additive latency minus two
// RULE18: a newer write restarts the write-strength window
// RULE19: strength switching latencies include additive latency as well
`timescale 1ns/10ps
module term_ctrl import term_pkg::*; #(
   parameter int DELAY_DEPTH = 32
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic ODT_PIN,
   input wire logic WR_CMD,
   input wire logic WR_CHOP,
   input wire logic DQ_DRIVE,
   output logic TERM_EN,
   output logic TERM_WR_SEL,
   output logic [2:0] TERM_CODE
);

   localparam int TAP_W = $clog2(DELAY_DEPTH);

   // -----------------------------------------------------------
   // timing at a glance
   // -----------------------------------------------------------
   // the pin is captured by s1 at edge n and by s2 one edge later, then enters
   // the delay line; the tap is picked so TERM_EN changes right after edge n + lat
   // a write sampled at edge n clears wcnt, which then counts edges since that write
   // write strength runs while lat <= wcnt < lat + 4 (chop) or lat + 6 (eight)
   // the clamp at three keeps the tap from going negative, so an illegal short
   // latency gives late termination rather than a wrapped tap
   // limitation: a cfg write while the pin is high moves the tap, so the current
   // termination window grows or shrinks by the change in latency

   st_s cur_ff;
   st_s nxt_st;
   logic [4:0] lat;
   logic [4:0] lat_raw;
   logic [TAP_W-1:0] tap;
   logic req_dly;
   logic term_enable;
   logic dyn_en;
   logic [5:0] cnw;
   logic addr_cfg;
   logic addr_stat;
   logic mapped;
   logic setup;
   logic access;

   // -----------------------------------------------------------
   // decoded configuration
   // -----------------------------------------------------------
   assign term_enable = (cur_ff.cfg.rtt_nom != 3'h0) || (cur_ff.cfg.rtt_wr != 2'h0); // [RULE16]
   assign dyn_en = (cur_ff.cfg.rtt_wr != 2'h0);                                      // [RULE4]
   // turn-on, turn-off and switch latency all share cwl + al - 2
   assign lat_raw = 5'({1'b0, cur_ff.cfg.cwl} + {1'b0, cur_ff.cfg.al} - LAT_OFFSET); // [RULE17] [RULE19]
   // clamp keeps an illegal small setting from underflowing the tap
   assign lat = ((cur_ff.cfg.cwl + cur_ff.cfg.al) < 5'(LAT_MIN + LAT_OFFSET)) ? LAT_MIN : lat_raw;
   assign cnw = {1'b0, lat};                                                         // [RULE8]
   // the two synchroniser flops already supply the first cycles of delay
   assign tap = TAP_W'(lat - LAT_MIN);

   // -----------------------------------------------------------
   // internal request delay line
   // -----------------------------------------------------------
   term_delay #(.DEPTH(DELAY_DEPTH), .TAP_W(TAP_W)) u_delay (
      .CLK(CLK),
      .RST(RST),
      .DIN(cur_ff.s2),
      .TAP(tap),
      .DOUT(req_dly)
   );

   // -----------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------
   assign addr_cfg = (PADDR == CFG_OFF);
   assign addr_stat = (PADDR == STAT_OFF);
   assign mapped = addr_cfg || addr_stat;
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign PREADY = 1'b1;
   assign PSLVERR = access && !mapped;  // unmapped: error, write dropped, data zero

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      logic [5:0] cwn;
      logic [CFG_W-1:0] wr_word;
      cwn = 6'h00;
      wr_word = cur_ff.cfg;
      nxt_st = cur_ff;
      nxt_st.s1 = ODT_PIN;
      nxt_st.s2 = cur_ff.s1;

      // configuration write with byte lanes
      if (access && PWRITE && addr_cfg) begin
         if (PSTRB[0]) begin
            wr_word[7:0] = PWDATA[7:0];
         end
         if (PSTRB[1]) begin
            wr_word[CFG_W-1:8] = PWDATA[CFG_W-1:8];
         end
         nxt_st.cfg = cfg_s'(wr_word);
      end

      // write-strength window, restarted by every new write
      if (WR_CMD) begin
         nxt_st.wcnt = 6'h00;               // [RULE18]
         nxt_st.chop = WR_CHOP;
         nxt_st.wact = dyn_en;
      end else if (cur_ff.wact) begin
         nxt_st.wcnt = cur_ff.wcnt + 6'h01;
      end
      cwn = (nxt_st.chop ? CHOP_EXTRA : EIGHT_EXTRA) + {1'b0, lat}; // [RULE9] [RULE10]
      if (!WR_CMD && nxt_st.wcnt >= cwn) begin
         nxt_st.wact = 1'b0;
      end
      nxt_st.wsel = nxt_st.wact && dyn_en && (nxt_st.wcnt >= cnw) && (nxt_st.wcnt < cwn); // [RULE8]

      // on/off from delayed pin only; drivers busy forces off
      nxt_st.term_en = req_dly && term_enable && !DQ_DRIVE; // [RULE3] [RULE11] [RULE15]
      nxt_st.code = nxt_st.wsel ? {1'b0, cur_ff.cfg.rtt_wr} : cur_ff.cfg.rtt_nom; // [RULE5] [RULE6] [RULE7]

      // read data captured in setup, so PRDATA comes from a flop
      if (setup) begin
         if (addr_cfg) begin
            nxt_st.rdata = {19'h0, cur_ff.cfg};
         end else if (addr_stat) begin
            nxt_st.rdata = {21'h0, cur_ff.s2, lat, cur_ff.code, cur_ff.wsel, cur_ff.term_en};
         end else begin
            nxt_st.rdata = 32'h0000_0000;
         end
      end
   end

   // -----------------------------------------------------------
   // state register
   // -----------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cur_ff <= ST_RST;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   assign PRDATA = cur_ff.rdata;
   assign TERM_EN = cur_ff.term_en;
   assign TERM_WR_SEL = cur_ff.wsel;
   assign TERM_CODE = cur_ff.code;

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   sequence pin_rise_lat3;
      $rose(cur_ff.s2) && lat == 5'h03 && term_enable;
   endsequence

   sequence quiet_bus;
      !DQ_DRIVE && term_enable && !(access && PWRITE);
   endsequence

   disabled_pin_off_a: assert property (@(posedge CLK) disable iff (RST) // [RULE16]
      !term_enable && !(access && PWRITE) |=> !TERM_EN)
      else $error("termination on while all selects are zero");

   driving_blocks_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
      DQ_DRIVE |=> !TERM_EN)
      else $error("termination on while output drivers busy");

   driver_release_a: assert property (@(posedge CLK) disable iff (RST) // [RULE3]
      $fell(DQ_DRIVE) && req_dly && term_enable |=> TERM_EN)
      else $error("termination not back after drivers released");

   turn_on_lat_a: assert property (@(posedge CLK) disable iff (RST) // [RULE15]
      pin_rise_lat3 ##1 quiet_bus |=> TERM_EN)
      else $error("termination not on three cycles after pin sampled");

   write_sel_start_a: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
      $rose(TERM_WR_SEL) |-> cur_ff.wcnt == cnw)
      else $error("write strength started at wrong latency");

   chop_return_a: assert property (@(posedge CLK) disable iff (RST) // [RULE9]
      $fell(TERM_WR_SEL) && cur_ff.chop && cur_ff.wcnt != 6'h00 && $stable(cur_ff.cfg)
      |-> cur_ff.wcnt == CHOP_EXTRA + {1'b0, lat})
      else $error("chop four write returned at wrong latency");

   eight_return_a: assert property (@(posedge CLK) disable iff (RST) // [RULE10]
      $fell(TERM_WR_SEL) && !cur_ff.chop && cur_ff.wcnt != 6'h00 && $stable(cur_ff.cfg)
      |-> cur_ff.wcnt == EIGHT_EXTRA + {1'b0, lat})
      else $error("length eight write returned at wrong latency");

   write_restart_a: assert property (@(posedge CLK) disable iff (RST) // [RULE18]
      WR_CMD |=> cur_ff.wcnt == 6'h00 && !TERM_WR_SEL)
      else $error("newer write did not restart the window");

   dyn_needed_a: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
      TERM_WR_SEL |-> $past(cur_ff.cfg.rtt_wr) != 2'h0)
      else $error("write strength selected with dynamic mode off");

   wr_code_a: assert property (@(posedge CLK) disable iff (RST) // [RULE6]
      TERM_WR_SEL |-> TERM_CODE == {1'b0, $past(cur_ff.cfg.rtt_wr)})
      else $error("write strength code wrong");

   nom_code_a: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
      !TERM_WR_SEL |-> TERM_CODE == $past(cur_ff.cfg.rtt_nom))
      else $error("nominal strength code wrong");

   write_keeps_on_a: assert property (@(posedge CLK) disable iff (RST) // [RULE11]
      WR_CMD && !req_dly |=> !TERM_EN)
      else $error("write switched termination on");

   // -----------------------------------------------------------
   // register bus, latency floor, write strength and turn-off
   // -----------------------------------------------------------
   // full-lane configuration store at the access edge
   sequence cfg_store;
      access && PWRITE && addr_cfg && (PSTRB[1:0] == 2'h3);
   endsequence

   // a write followed by two quiet cycles; the clamp keeps lat at three or more
   sequence write_then_idle;
      WR_CMD ##1 (!WR_CMD) [*2];
   endsequence

   // pin fall seen by the second sync flop, with no write moving the tap
   sequence pin_fall_lat3;
      $fell(cur_ff.s2) && lat == 5'h03 && !(access && PWRITE);
   endsequence

   cfg_write_a: assert property (@(posedge CLK) disable iff (RST) // [RULE5] [RULE6]
      cfg_store |=> cur_ff.cfg == $past(PWDATA[CFG_W-1:0]))
      else $error("configuration write did not land");

   cfg_kept_a: assert property (@(posedge CLK) disable iff (RST)
      !(access && PWRITE && addr_cfg) |=> $stable(cur_ff.cfg))
      else $error("configuration changed without a write");

   cfg_readback_a: assert property (@(posedge CLK) disable iff (RST)
      setup && addr_cfg |=> PRDATA == {19'h0, $past(cur_ff.cfg)})
      else $error("configuration read back wrong");

   unmapped_read_a: assert property (@(posedge CLK) disable iff (RST)
      setup && !mapped |=> PRDATA == 32'h0000_0000)
      else $error("unmapped read returned data");

   err_phase_a: assert property (@(posedge CLK) disable iff (RST)
      PSLVERR |-> access && !mapped)
      else $error("error response outside an unmapped access");

   stat_lat_a: assert property (@(posedge CLK) disable iff (RST) // [RULE17]
      setup && addr_stat |=> PRDATA[9:5] == $past(lat))
      else $error("status shows wrong latency");

   early_sel_a: assert property (@(posedge CLK) disable iff (RST) // [RULE8]
      write_then_idle |=> !TERM_WR_SEL)
      else $error("write strength selected too early");

   dyn_off_a: assert property (@(posedge CLK) disable iff (RST) // [RULE4]
      !dyn_en |=> !TERM_WR_SEL)
      else $error("write strength kept after dynamic mode cleared");

   window_only_a: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
      !cur_ff.wact |-> !TERM_WR_SEL)
      else $error("write strength outside a write window");

   turn_off_lat_a: assert property (@(posedge CLK) disable iff (RST) // [RULE15]
      pin_fall_lat3 |-> ##2 !TERM_EN)
      else $error("termination not off three cycles after pin sampled low");

endmodule

// *** sim/ctl_model.sv ***
// Purpose: memory controller model driving the pin, write commands and read traffic
// Assumes: every task is entered just after a rising edge of CLK
// Notes:   the pin is only ever driven in one task at a time, never two
`timescale 1ns/10ps
module ctl_model (
   input wire logic CLK,
   output logic ODT_PIN,
   output logic WR_CMD,
   output logic WR_CHOP,
   output logic DQ_DRIVE
);
   // idle controller: pin low, no command, data bus released
   initial begin
      ODT_PIN = 1'b0;
      WR_CMD = 1'b0;
      WR_CHOP = 1'b0;
      DQ_DRIVE = 1'b0;
   end
   // pin high for n cycles; short requests are stretched to the minimum
   task automatic pin_high(input int n);
      ODT_PIN <= 1'b1;
      repeat ((n < 4) ? 4 : n) @(posedge CLK);
      ODT_PIN <= 1'b0;
   endtask
   // write with the pin high, optionally a second write gap cycles later
   task automatic write(input logic chop, input int gap);
      ODT_PIN <= 1'b1;
      WR_CMD <= 1'b1;
      WR_CHOP <= chop;
      @(posedge CLK);
      WR_CMD <= 1'b0;
      if (gap > 0) begin
         repeat (gap - 1) @(posedge CLK);
         WR_CMD <= 1'b1;
         @(posedge CLK);
         WR_CMD <= 1'b0;
      end
      repeat (chop ? 4 : 6) @(posedge CLK);
      ODT_PIN <= 1'b0;
   endtask
   // read burst: caller has already dropped the pin; it stays low until the bus is free
   task automatic read();
      DQ_DRIVE <= 1'b1;
      repeat (2) @(posedge CLK);
      DQ_DRIVE <= 1'b0;
   endtask
endmodule

// *** sim/dram_on_die_termination_ctrl_test.sv ***
// Purpose: self-checking bench of the termination control
// Assumes: zero-wait APB slave, controller model on the pin side
// Notes:   latencies are worked out from cwl and al per scenario
`timescale 1ns/10ps
module dram_on_die_termination_ctrl_test;
   import term_pkg::*;
   // ----------------------------------------------------------------
   // signals and helpers
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, odt, wcmd, wchop, dq, term_en, wr_sel;
   logic [2:0] code;
   int n_mismatch = 0;
   int checks_done = 0;
   int lat;
   always #4 clk = ~clk;
   ctl_model u_ctl (.CLK(clk), .ODT_PIN(odt), .WR_CMD(wcmd), .WR_CHOP(wchop), .DQ_DRIVE(dq));
   term_ctrl u_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .ODT_PIN(odt), .WR_CMD(wcmd), .WR_CHOP(wchop), .DQ_DRIVE(dq),
      .TERM_EN(term_en), .TERM_WR_SEL(wr_sel), .TERM_CODE(code));
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // skip n edges and settle past the updates before looking
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one apb transfer launched on an edge; only the watchdog ends a wait on pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cfg(input int al, input int cwl, input int wrs, input int nom);
      apb(1'b1, CFG_OFF, {19'h0, 4'(al), 4'(cwl), 2'(wrs), 3'(nom)});
      lat = (cwl + al < 5) ? 3 : cwl + al - 2;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      look(0);
      cmp("term_en", 0, 32'(term_en));
      apb(1'b0, CFG_OFF, 0);
      cmp("cfg reset", 32'h0000_00a0, rd);
      apb(1'b0, 12'h008, 0);
      cmp("unmapped err", 1, 32'(err));
      apb(1'b1, STAT_OFF, 32'hffff_ffff);
      apb(1'b0, STAT_OFF, 0);
      cmp("stat lat", 3, 32'(rd[9:5]));
      u_ctl.pin_high(4);
      look(6);
      cmp("pin ignored", 0, 32'(term_en));
   endtask
   // on and off timing for two latency settings, the clamp among them
   task automatic t_onoff(input int al, input int cwl);
      cfg(al, cwl, 0, 5);
      fork
         u_ctl.pin_high(8);
         begin
            look(lat);
            cmp("early on", 0, 32'(term_en));
            look(1);
            cmp("on", 1, 32'(term_en));
            cmp("nom code", 5, 32'(code));
         end
      join
      look(lat);
      cmp("late off", 1, 32'(term_en));
      look(1);
      cmp("off", 0, 32'(term_en));
   endtask
   task automatic t_write(input logic chop);
      cfg(2, 5, 2, 1);
      fork
         u_ctl.write(chop, 0);
         begin
            look(lat);
            cmp("sel early", 0, 32'(wr_sel));
            look(1);
            cmp("sel", 1, 32'(wr_sel));
            cmp("wr code", 2, 32'(code));
            cmp("en in write", 1, 32'(term_en));
            look(chop ? 3 : 5);
            cmp("sel hold", 1, 32'(wr_sel));
            look(1);
            cmp("sel back", 0, 32'(wr_sel));
            cmp("nom back", 1, 32'(code));
         end
      join
   endtask
   task automatic t_restart();
      cfg(0, 5, 1, 1);
      fork
         u_ctl.write(1'b0, 2);
         begin
            look(lat + 8);
            cmp("restart hold", 1, 32'(wr_sel));
            look(1);
            cmp("restart end", 0, 32'(wr_sel));
         end
      join
      cfg(0, 5, 0, 1);
      fork
         u_ctl.write(1'b1, 0);
         begin
            look(lat + 1);
            cmp("no dynamic", 0, 32'(wr_sel));
            cmp("en plain", 1, 32'(term_en));
         end
      join
   endtask
   task automatic t_read();
      cfg(2, 6, 0, 1);
      u_ctl.pin_high(8);
      fork
         u_ctl.read();
         begin
            look(2);
            cmp("off while driving", 0, 32'(term_en));
            look(3);
            cmp("on after release", 1, 32'(term_en));
            look(3);
            cmp("off delayed", 0, 32'(term_en));
         end
      join
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_onoff(2, 6);
      t_onoff(0, 4);
      t_write(1'b1);
      t_write(1'b0);
      t_restart();
      t_read();
      end_sim();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end
endmodule
